// file: inc/bobx_pkg.sv
// Notes on behaviour
// RULE1: bit number is 3-bit immediate field
// RULE2: carry xor inverted bit into carry
// RULE3: load selected bit into carry
// RULE4: load inverted selected bit into carry
// RULE5: store carry into selected bit
// RULE6: store inverted carry into selected bit
// RULE7: store zero flag to memory bit only
// RULE8: store inverted zero flag to memory bit
// RULE9: extract memory field right-aligned into register
// RULE10: insert register low bits into memory field
// RULE11: branch on memory bit set or clear
// RULE12: call on memory bit set or clear
// RULE13: conditional branch when condition true
// RULE14: delayed branch runs next instruction first
// RULE15: delay slot holds one-word non-branch instruction
// RULE16: jump unconditional, no slot, no linkage
// RULE17: calls transfer and save return point
// RULE18: return resumes; extended pops registers first
// RULE19: instructions are 16-bit units, two bytes
// RULE20: condition comes from instruction condition field
// RULE21: stores keep unselected destination bits
// RULE22: loads change only carry; stores no flags
package bobx_pkg;

  // ==========================================================
  // operations
  typedef enum logic [4:0] {
    XOR_CARRY_INVERTED_BIT = 5'h00,
    LOAD_BIT_TO_CARRY = 5'h01,
    LOAD_INVERTED_BIT_TO_CARRY = 5'h02,
    STORE_CARRY_TO_BIT = 5'h03,
    STORE_INVERTED_CARRY_TO_BIT = 5'h04,
    STORE_ZERO_FLAG_TO_BIT = 5'h05,
    STORE_INVERTED_ZERO_FLAG_TO_BIT = 5'h06,
    FIELD_EXTRACT = 5'h07,
    FIELD_INSERT = 5'h08,
    BRANCH_IF_MEMORY_BIT_SET = 5'h09,
    BRANCH_IF_MEMORY_BIT_CLEAR = 5'h0a,
    CALL_IF_MEMORY_BIT_SET = 5'h0b,
    CALL_IF_MEMORY_BIT_CLEAR = 5'h0c,
    COND_BRANCH = 5'h0d,
    DELAYED_BRANCH = 5'h0e,
    ABSOLUTE_JUMP = 5'h0f,
    RELATIVE_CALL = 5'h10,
    ABSOLUTE_CALL = 5'h11,
    SUB_RETURN = 5'h12,
    SUB_RETURN_POP = 5'h13
  } bobx_op_t;

  // ==========================================================
  // carriers
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } bobx_flags_t;

  typedef struct packed {
    bobx_op_t op;
    logic [2:0] bitno;
    logic [3:0] cc;
    logic [7:0] fmask;
    logic mem_opnd;
    logic [7:0] rsrc;
    logic [3:0] ridx;
    logic [3:0] pop_cnt;
    logic [2:0] words;
    logic [31:0] pc;
    logic [31:0] target;
    logic [31:0] ea;
  } bobx_instr_t;

  // ==========================================================
  // constants
  localparam logic [31:0] BOBX_UNIT_BYTES = 32'h0000_0002;
  localparam logic [3:0] BOBX_BE_BYTE = 4'h1;
  localparam logic [3:0] BOBX_BE_WORD = 4'hf;
  localparam logic [3:0] BOBX_RIDX_STEP = 4'h1;
  localparam logic [31:0] BOBX_RST_ADDR = 32'h0000_0000;
  localparam logic [7:0] BOBX_RST_BYTE = 8'h00;

endpackage

// file: verilog/bobx_cond.sv
`timescale 1ns/1ps
module bobx_cond (
  input wire logic [3:0] cc,
  input bobx_pkg::bobx_flags_t flags,
  output logic ok
);
  logic base;

  // ==========================================================
  // condition field evaluation
  // RULE20 condition field select
  always_comb begin
    unique case (cc[3:1])
      3'h0: base = 1'b1;
      3'h1: base = ~(flags.c | flags.z);
      3'h2: base = ~flags.c;
      3'h3: base = ~flags.z;
      3'h4: base = ~flags.v;
      3'h5: base = ~flags.n;
      3'h6: base = ~(flags.n ^ flags.v);
      3'h7: base = ~flags.z & ~(flags.n ^ flags.v);
    endcase
  end

  assign ok = base ^ cc[0];
endmodule // bobx_cond

// file: verilog/bobx_bit_unit.sv
`timescale 1ns/1ps
module bobx_bit_unit (
  input bobx_pkg::bobx_op_t op,
  input wire logic [7:0] opnd,
  input wire logic [2:0] bitno,
  input wire logic [7:0] fmask,
  input wire logic [7:0] rsrc,
  input bobx_pkg::bobx_flags_t flags,
  output logic bit_v,
  output logic c_new,
  output logic [7:0] st_byte,
  output logic [7:0] fld_ext,
  output logic [7:0] fld_ins
);
  logic st_v;
  logic [2:0] lsb;
  logic [7:0] sh;

  // ==========================================================
  // bit select and carry result
  // RULE1 immediate bit select
  assign bit_v = opnd[bitno];

  always_comb begin
    unique case (op)
      // RULE2 xor inverted bit
      bobx_pkg::XOR_CARRY_INVERTED_BIT: c_new = flags.c ^ ~bit_v;
      // RULE3 load bit
      bobx_pkg::LOAD_BIT_TO_CARRY: c_new = bit_v;
      // RULE4 load inverted bit
      bobx_pkg::LOAD_INVERTED_BIT_TO_CARRY: c_new = ~bit_v;
      default: c_new = flags.c;
    endcase
  end

  always_comb begin
    unique case (op)
      // RULE5 store carry
      bobx_pkg::STORE_CARRY_TO_BIT: st_v = flags.c;
      // RULE6 store inverted carry
      bobx_pkg::STORE_INVERTED_CARRY_TO_BIT: st_v = ~flags.c;
      // RULE7 store zero flag
      bobx_pkg::STORE_ZERO_FLAG_TO_BIT: st_v = flags.z;
      // RULE8 store inverted zero
      bobx_pkg::STORE_INVERTED_ZERO_FLAG_TO_BIT: st_v = ~flags.z;
      default: st_v = bit_v;
    endcase
  end

  // ==========================================================
  // field position
  always_comb begin
    lsb = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (fmask[i]) begin
        lsb = 3'(i);
      end
    end
  end

  // RULE9 right-aligned extract
  assign fld_ext = (opnd & fmask) >> lsb;
  assign sh = rsrc << lsb;

  // ==========================================================
  // merge per bit
  // RULE21 keep unselected bits
  for (genvar i = 0; i < 8; i++) begin : g_bit
    assign st_byte[i] = (bitno == 3'(i)) ? st_v : opnd[i];
    // RULE10 field insert merge
    assign fld_ins[i] = fmask[i] ? sh[i] : opnd[i];
  end
endmodule // bobx_bit_unit

// file: verilog/bobx_exec.sv
`timescale 1ns/1ps
module bobx_exec (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic issue_valid,
  input bobx_pkg::bobx_instr_t issue_ins,
  input bobx_pkg::bobx_flags_t flags_in,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  input wire logic [31:0] stk_rdata,
  input wire logic stk_ack,
  output logic busy_q,
  output logic done_q,
  output logic c_we_q,
  output logic c_out_q,
  output logic pc_load_q,
  output logic [31:0] pc_addr_q,
  output logic mem_req_q,
  output logic mem_we_q,
  output logic [31:0] mem_addr_q,
  output logic [7:0] mem_wdata_q,
  output logic stk_req_q,
  output logic stk_push_q,
  output logic [31:0] stk_wdata_q,
  output logic rw_en_q,
  output logic [3:0] rw_idx_q,
  output logic [3:0] rw_be_q,
  output logic [31:0] rw_data_q
);
  typedef enum logic [6:0] {
    S_IDLE = 7'b000_0001,
    S_READ = 7'b000_0010,
    S_EXEC = 7'b000_0100,
    S_WRITE = 7'b000_1000,
    S_PUSH = 7'b001_0000,
    S_POP = 7'b010_0000,
    S_DONE = 7'b100_0000
  } bobx_state_t;

  bobx_state_t st_q;
  bobx_state_t st_d;
  bobx_pkg::bobx_instr_t ins_q;
  bobx_pkg::bobx_flags_t flg_q;
  logic [7:0] opnd_q;
  logic [3:0] cnt_q;
  logic [3:0] ridx_q;
  logic [31:0] ret_q;
  logic [31:0] dbr_tgt_q;
  logic pend_q;
  logic accept;
  logic mem_only;
  logic need_rd;
  logic is_mem;
  logic is_cload;
  logic is_sstore;
  logic is_call_bit;
  logic is_call;
  logic is_ret;
  logic take;
  logic xfer;
  logic cond_ok;
  logic bu_bit;
  logic bu_c;
  logic [7:0] bu_st;
  logic [7:0] bu_ext;
  logic [7:0] bu_ins;
  logic [31:0] ret_pc;

  // ==========================================================
  // helpers
  bobx_bit_unit u_bit (
    .op(ins_q.op),
    .opnd(opnd_q),
    .bitno(ins_q.bitno),
    .fmask(ins_q.fmask),
    .rsrc(ins_q.rsrc),
    .flags(flg_q),
    .bit_v(bu_bit),
    .c_new(bu_c),
    .st_byte(bu_st),
    .fld_ext(bu_ext),
    .fld_ins(bu_ins)
  );

  bobx_cond u_cond (
    .cc(ins_q.cc),
    .flags(flg_q),
    .ok(cond_ok)
  );

  // ==========================================================
  // decode of the issued instruction
  always_comb begin
    mem_only = issue_ins.op inside {
      bobx_pkg::STORE_ZERO_FLAG_TO_BIT,
      bobx_pkg::STORE_INVERTED_ZERO_FLAG_TO_BIT,
      bobx_pkg::FIELD_EXTRACT, bobx_pkg::FIELD_INSERT,
      bobx_pkg::BRANCH_IF_MEMORY_BIT_SET,
      bobx_pkg::BRANCH_IF_MEMORY_BIT_CLEAR,
      bobx_pkg::CALL_IF_MEMORY_BIT_SET,
      bobx_pkg::CALL_IF_MEMORY_BIT_CLEAR};
    need_rd = mem_only | (issue_ins.mem_opnd &&
      issue_ins.op <= bobx_pkg::STORE_INVERTED_CARRY_TO_BIT);
  end

  assign accept = issue_valid & (st_q == S_IDLE);
  // RULE7 zero-flag stores forced to memory
  assign is_mem = ins_q.mem_opnd |
    (ins_q.op == bobx_pkg::STORE_ZERO_FLAG_TO_BIT) |
    (ins_q.op == bobx_pkg::STORE_INVERTED_ZERO_FLAG_TO_BIT);
  assign is_cload = ins_q.op <= bobx_pkg::LOAD_INVERTED_BIT_TO_CARRY;
  assign is_sstore = ins_q.op inside {
    [bobx_pkg::STORE_CARRY_TO_BIT:
     bobx_pkg::STORE_INVERTED_ZERO_FLAG_TO_BIT]};
  assign is_call_bit = ins_q.op inside {
    bobx_pkg::CALL_IF_MEMORY_BIT_SET,
    bobx_pkg::CALL_IF_MEMORY_BIT_CLEAR};
  assign is_call = ins_q.op inside {
    bobx_pkg::RELATIVE_CALL, bobx_pkg::ABSOLUTE_CALL};
  assign is_ret = ins_q.op inside {
    bobx_pkg::SUB_RETURN, bobx_pkg::SUB_RETURN_POP};
  // RULE19 return point in 2-byte units
  assign ret_pc = ins_q.pc + 32'(ins_q.words) * bobx_pkg::BOBX_UNIT_BYTES;

  // ==========================================================
  // transfer decision
  always_comb begin
    unique case (ins_q.op)
      // RULE11 bit-test branch
      bobx_pkg::BRANCH_IF_MEMORY_BIT_SET,
      bobx_pkg::CALL_IF_MEMORY_BIT_SET: take = bu_bit;
      bobx_pkg::BRANCH_IF_MEMORY_BIT_CLEAR,
      bobx_pkg::CALL_IF_MEMORY_BIT_CLEAR: take = ~bu_bit;
      // RULE13 conditional branch
      bobx_pkg::COND_BRANCH: take = cond_ok;
      // RULE16 unconditional jump, also relative/absolute calls and returns always taken
      bobx_pkg::ABSOLUTE_JUMP,
      bobx_pkg::RELATIVE_CALL, bobx_pkg::ABSOLUTE_CALL,
      bobx_pkg::SUB_RETURN, bobx_pkg::SUB_RETURN_POP: take = 1'b1;
      default: take = 1'b0;
    endcase
  end

  assign xfer = take | pend_q;

  // ==========================================================
  // sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      S_IDLE: begin
        if (accept) begin
          st_d = need_rd ? S_READ : S_EXEC;
        end
      end
      S_READ: begin
        if (mem_ack) begin
          st_d = S_EXEC;
        end
      end
      S_EXEC: begin
        if ((is_sstore && is_mem) ||
            ins_q.op == bobx_pkg::FIELD_INSERT) begin
          st_d = S_WRITE;
        end else if (is_call || (is_call_bit && take)) begin
          // RULE12 call when bit matches, or any relative/absolute call
          st_d = S_PUSH;
        end else if (is_ret) begin
          st_d = S_POP;
        end else begin
          st_d = S_DONE;
        end
      end
      S_WRITE: begin
        if (mem_ack) begin
          st_d = S_DONE;
        end
      end
      S_PUSH: begin
        if (stk_ack) begin
          st_d = S_DONE;
        end
      end
      S_POP: begin
        if (stk_ack && cnt_q == 4'h0) begin
          st_d = S_DONE;
        end
      end
      S_DONE: st_d = S_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      st_q <= S_IDLE;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      st_q <= st_d;
      busy_q <= st_d != S_IDLE;
      done_q <= st_q == S_DONE;
    end
  end

  // ==========================================================
  // instruction and operand capture
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ins_q <= '0;
      flg_q <= '0;
      opnd_q <= bobx_pkg::BOBX_RST_BYTE;
    end else if (accept) begin
      ins_q <= issue_ins;
      flg_q <= flags_in;
      opnd_q <= issue_ins.rsrc;
    end else if (st_q == S_READ && mem_ack) begin
      opnd_q <= mem_rdata;
    end
  end

  // ==========================================================
  // memory port, read-modify-write of the operand byte
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mem_req_q <= 1'b0;
      mem_we_q <= 1'b0;
      mem_addr_q <= bobx_pkg::BOBX_RST_ADDR;
      mem_wdata_q <= bobx_pkg::BOBX_RST_BYTE;
    end else begin
      mem_req_q <= st_d == S_READ || st_d == S_WRITE;
      mem_we_q <= st_d == S_WRITE;
      if (accept) begin
        mem_addr_q <= issue_ins.ea;
      end
      // RULE21 write back merged byte
      if (st_q == S_EXEC) begin
        mem_wdata_q <= (ins_q.op == bobx_pkg::FIELD_INSERT) ?
          bu_ins : bu_st;
      end
    end
  end

  // ==========================================================
  // stack port
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      stk_req_q <= 1'b0;
      stk_push_q <= 1'b0;
      stk_wdata_q <= bobx_pkg::BOBX_RST_ADDR;
      cnt_q <= 4'h0;
      ret_q <= bobx_pkg::BOBX_RST_ADDR;
    end else begin
      stk_req_q <= st_d == S_PUSH || st_d == S_POP;
      stk_push_q <= st_d == S_PUSH;
      // RULE17 push return point
      if (st_q == S_EXEC) begin
        stk_wdata_q <= ret_pc;
        // RULE18 extended return pops registers
        cnt_q <= (ins_q.op == bobx_pkg::SUB_RETURN_POP) ?
          ins_q.pop_cnt : 4'h0;
      end else if (st_q == S_POP && stk_ack) begin
        if (cnt_q != 4'h0) begin
          cnt_q <= cnt_q - 4'h1;
        end else begin
          ret_q <= stk_rdata;
        end
      end
    end
  end

  // ==========================================================
  // carry flag result
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      c_we_q <= 1'b0;
      c_out_q <= 1'b0;
    end else begin
      // RULE22 only carry ops touch flags
      c_we_q <= st_q == S_DONE && is_cload;
      if (st_q == S_DONE) begin
        c_out_q <= bu_c;
      end
    end
  end

  // ==========================================================
  // general register writes
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rw_en_q <= 1'b0;
      rw_idx_q <= 4'h0;
      rw_be_q <= 4'h0;
      rw_data_q <= bobx_pkg::BOBX_RST_ADDR;
      ridx_q <= 4'h0;
    end else begin
      rw_en_q <= 1'b0;
      if (st_q == S_EXEC) begin
        ridx_q <= ins_q.ridx;
      end
      if (st_q == S_POP && stk_ack && cnt_q != 4'h0) begin
        // RULE18 restore registers in order
        rw_en_q <= 1'b1;
        rw_idx_q <= ridx_q;
        rw_be_q <= bobx_pkg::BOBX_BE_WORD;
        rw_data_q <= stk_rdata;
        ridx_q <= ridx_q + bobx_pkg::BOBX_RIDX_STEP;
      end else if (st_q == S_DONE &&
                   (ins_q.op == bobx_pkg::FIELD_EXTRACT ||
                    (is_sstore && !is_mem))) begin
        // RULE9 extract lands in low bits
        rw_en_q <= 1'b1;
        rw_idx_q <= ins_q.ridx;
        rw_be_q <= bobx_pkg::BOBX_BE_BYTE;
        rw_data_q <= {24'h00_0000,
          (ins_q.op == bobx_pkg::FIELD_EXTRACT) ? bu_ext : bu_st};
      end
    end
  end

  // ==========================================================
  // program counter redirect
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pc_load_q <= 1'b0;
      pc_addr_q <= bobx_pkg::BOBX_RST_ADDR;
      pend_q <= 1'b0;
      dbr_tgt_q <= bobx_pkg::BOBX_RST_ADDR;
    end else begin
      pc_load_q <= 1'b0;
      if (st_q == S_DONE) begin
        if (ins_q.op == bobx_pkg::DELAYED_BRANCH) begin
          // RULE14 wait for delay slot
          pend_q <= 1'b1;
          dbr_tgt_q <= ins_q.target;
        end else if (xfer) begin
          pc_load_q <= 1'b1;
          pend_q <= 1'b0;
          pc_addr_q <= pend_q ? dbr_tgt_q :
            (is_ret ? ret_q : ins_q.target);
        end
      end
    end
  end

  // ==========================================================
  // checks
  AST_BIT_LOAD: assert property ( // RULE3
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_DONE && ins_q.op == bobx_pkg::LOAD_BIT_TO_CARRY
    |=> c_we_q && c_out_q == $past(opnd_q[ins_q.bitno]))
    else $error("carry not loaded from selected bit");

  AST_BIT_LOAD_INV: assert property ( // RULE4
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_DONE &&
    ins_q.op == bobx_pkg::LOAD_INVERTED_BIT_TO_CARRY
    |=> c_we_q && c_out_q == !$past(bu_bit))
    else $error("carry not loaded from inverted bit");

  AST_XOR_INV: assert property ( // RULE2
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_DONE &&
    ins_q.op == bobx_pkg::XOR_CARRY_INVERTED_BIT
    |=> c_we_q && c_out_q == ($past(flg_q.c) ^ !$past(bu_bit)))
    else $error("carry xor inverted bit wrong");

  AST_STORE_KEEP: assert property ( // RULE21
    @(posedge mclk) disable iff (sys_rst)
    mem_we_q && mem_ack && is_sstore
    |-> ((mem_wdata_q ^ opnd_q) & ~(8'h01 << ins_q.bitno)) == 8'h00)
    else $error("store changed unselected bits");

  AST_ZERO_STORE: assert property ( // RULE7
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_WRITE && ins_q.op == bobx_pkg::STORE_ZERO_FLAG_TO_BIT
    |-> mem_we_q && mem_wdata_q[ins_q.bitno] == flg_q.z)
    else $error("zero flag not stored to memory bit");

  AST_STORE_NOFLAG: assert property ( // RULE22
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_DONE && !is_cload |=> !c_we_q)
    else $error("flags written by non-carry op");

  AST_COND: assert property ( // RULE13
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_DONE && !pend_q &&
    ins_q.op == bobx_pkg::COND_BRANCH
    |=> pc_load_q == $past(cond_ok))
    else $error("conditional branch mismatch");

  AST_JUMP: assert property ( // RULE16
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_EXEC && !pend_q &&
    ins_q.op == bobx_pkg::ABSOLUTE_JUMP
    |=> !stk_req_q ##1 pc_load_q && pc_addr_q == $past(ins_q.target, 2))
    else $error("jump did not redirect");

  AST_CALL_PUSH: assert property ( // RULE17
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_EXEC && is_call
    |=> stk_req_q && stk_push_q && stk_wdata_q == $past(ret_pc))
    else $error("call did not push return point");

  AST_DELAY: assert property ( // RULE14
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_DONE && ins_q.op == bobx_pkg::DELAYED_BRANCH
    |=> !pc_load_q && pend_q)
    else $error("delayed branch redirected early");

  AST_DELAY_FIRE: assert property ( // RULE14
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_DONE && pend_q &&
    ins_q.op != bobx_pkg::DELAYED_BRANCH
    |=> pc_load_q && pc_addr_q == $past(dbr_tgt_q))
    else $error("delay slot did not end in target");

  AST_RETURN: assert property ( // RULE18
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_POP && stk_ack && cnt_q == 4'h0 && !pend_q
    |=> ##1 pc_load_q && pc_addr_q == $past(stk_rdata, 2))
    else $error("return point not resumed");

  AST_BIT_BRANCH: assert property ( // RULE11
    @(posedge mclk) disable iff (sys_rst)
    st_q == S_DONE && !pend_q &&
    ins_q.op == bobx_pkg::BRANCH_IF_MEMORY_BIT_CLEAR
    |=> pc_load_q == !$past(bu_bit))
    else $error("bit-clear branch mismatch");
endmodule // bobx_exec

// file: test/bobx_exec_test.sv
`timescale 1ns/1ps
module bobx_exec_test;
  // ==========================================================
  // signals
  logic mclk;
  logic sys_rst = 1'h1;
  logic issue_valid = 1'h0;
  bobx_pkg::bobx_instr_t issue_ins = '0;
  bobx_pkg::bobx_flags_t flags_in = '0;
  logic [7:0] mem_rdata = 8'h00;
  logic mem_ack = 1'h0;
  logic [31:0] stk_rdata = 32'h0000_0000;
  logic stk_ack = 1'h0;
  logic busy_q, done_q, c_we_q, c_out_q, pc_load_q;
  logic mem_req_q, mem_we_q, stk_req_q, stk_push_q, rw_en_q;
  logic [31:0] pc_addr_q, mem_addr_q, stk_wdata_q, rw_data_q;
  logic [7:0] mem_wdata_q;
  logic [3:0] rw_idx_q, rw_be_q;
  bobx_pkg::bobx_instr_t ins = '0;
  logic [7:0] mem_byte = 8'h00;
  logic [7:0] mem_wr = 8'h00;
  logic [31:0] mem_a = 32'h0000_0000;
  logic [31:0] pops [4];
  logic [31:0] push_w = 32'h0000_0000;
  logic [31:0] rw_d [8];
  logic [3:0] rw_i [8];
  logic [3:0] rw_b = 4'h0;
  logic dn_c, dn_cwe, dn_pl;
  logic [31:0] dn_pa;
  int pi = 0;
  int pushes = 0;
  int rw_n = 0;
  int cyc = 0;
  int err_total = 0;
  int checks_done = 0;

  bobx_exec i_bobx_exec (
    .mclk, .sys_rst, .issue_valid, .issue_ins, .flags_in, .mem_rdata,
    .mem_ack, .stk_rdata, .stk_ack, .busy_q, .done_q, .c_we_q, .c_out_q,
    .pc_load_q, .pc_addr_q, .mem_req_q, .mem_we_q, .mem_addr_q,
    .mem_wdata_q, .stk_req_q, .stk_push_q, .stk_wdata_q, .rw_en_q,
    .rw_idx_q, .rw_be_q, .rw_data_q
  );

  initial begin
    mclk = 1'h0;
    forever #12.5 mclk = ~mclk;
  end

  // ==========================================================
  // memory, stack and register-file responders
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    mem_ack <= mem_req_q && !mem_ack;
    mem_rdata <= (mem_req_q && !mem_ack) ? mem_byte : ~mem_byte;
    if (mem_ack && mem_we_q) mem_wr <= mem_wdata_q;
    if (mem_ack) mem_a <= mem_addr_q;
    stk_ack <= stk_req_q && !stk_ack;
    stk_rdata <= ~stk_rdata;
    if (stk_req_q && !stk_ack && !stk_push_q) begin
      stk_rdata <= pops[pi[1:0]];
      pi <= pi + 1;
    end
    if (stk_ack && stk_push_q) begin
      pushes <= pushes + 1;
      push_w <= stk_wdata_q;
    end
    if (rw_en_q) begin
      rw_i[rw_n[2:0]] <= rw_idx_q;
      rw_d[rw_n[2:0]] <= rw_data_q;
      rw_b <= rw_be_q;
      rw_n <= rw_n + 1;
    end
    if (cyc == 6000) begin
      err_total++;
      wrap_up();
    end
  end

  // ==========================================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      err_total++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic run(input bobx_pkg::bobx_flags_t f);
    int k;
    k = 0;
    @(posedge mclk);
    issue_valid <= 1'h1;
    issue_ins <= ins;
    flags_in <= f;
    @(posedge mclk);
    issue_valid <= 1'h0;
    @(negedge mclk);
    chk(busy_q, 1'h1);
    do begin
      @(negedge mclk);
      k++;
    end while (done_q !== 1'h1 && k < 60);
    chk(done_q, 1'h1);
    chk(busy_q, 1'h0);
    dn_c = c_out_q;
    dn_cwe = c_we_q;
    dn_pl = pc_load_q;
    dn_pa = pc_addr_q;
    @(negedge mclk);
  endtask

  function automatic logic cond_ok(input logic [3:0] cc,
                                   input bobx_pkg::bobx_flags_t f);
    logic r;
    case (cc[3:1])
      3'h0: r = 1'h1;
      3'h1: r = !(f.c | f.z);
      3'h2: r = !f.c;
      3'h3: r = !f.z;
      3'h4: r = !f.v;
      3'h5: r = !f.n;
      3'h6: r = !(f.n ^ f.v);
      default: r = !(f.z | (f.n ^ f.v));
    endcase
    return r ^ cc[0];
  endfunction

  // ==========================================================
  // scenarios
  task automatic t_carry();
    logic b;
    logic e;
    for (int op = 0; op < 3; op++) begin
      for (int n = 0; n < 8; n++) begin
        ins.op = bobx_pkg::bobx_op_t'(op);
        ins.bitno = n[2:0];
        ins.mem_opnd = n[0];
        ins.rsrc = 8'h5a;
        mem_byte = 8'h3c;
        b = n[0] ? mem_byte[n] : ins.rsrc[n];
        e = op == 0 ? (n[1] ^ ~b) : (op == 1 ? b : ~b);
        run({3'h0, n[1]});
        chk(dn_cwe, 1'h1);
        chk(dn_pl, 1'h0);
        chk(dn_c, e);
      end
    end
    $display("carry ops finished");
  endtask

  task automatic t_store();
    logic v;
    logic [7:0] e;
    int rn;
    bobx_pkg::bobx_flags_t f;
    for (int op = 3; op < 7; op++) begin
      f = {1'h0, op[0], 1'h0, op[1]};
      ins.op = bobx_pkg::bobx_op_t'(op);
      ins.bitno = op[2:0];
      ins.mem_opnd = (op == 3);
      ins.rsrc = 8'h69;
      ins.ridx = 4'h2;
      mem_byte = 8'h96;
      v = op == 3 ? f.c : (op == 4 ? ~f.c : (op == 5 ? f.z : ~f.z));
      e = (op == 4) ? ins.rsrc : mem_byte;
      e[op] = v;
      rn = rw_n;
      run(f);
      chk(dn_cwe, 1'h0);
      if (op == 4) begin
        chk(rw_d[rn[2:0]], {24'h00_0000, e});
        chk(rw_b, 4'h1);
        chk(rw_i[rn[2:0]], 4'h2);
      end else begin
        chk(mem_wr, e);
        chk(rw_n - rn, 0);
      end
    end
    $display("bit stores finished");
  endtask

  task automatic t_field();
    int rn;
    rn = rw_n;
    ins.op = bobx_pkg::FIELD_EXTRACT;
    ins.fmask = 8'h3c;
    ins.ridx = 4'h3;
    mem_byte = 8'hb6;
    run(4'h0);
    chk(rw_d[rn[2:0]], 32'h0000_000d);
    chk(rw_i[rn[2:0]], 4'h3);
    chk(mem_a, 32'h0000_0040);
    ins.op = bobx_pkg::FIELD_INSERT;
    ins.fmask = 8'h38;
    ins.rsrc = 8'h05;
    run(4'h0);
    chk(mem_wr, 8'hae);
    $display("field ops finished");
  endtask

  task automatic t_btest();
    logic tk;
    int p0;
    for (int op = 9; op < 13; op++) begin
      for (int v = 0; v < 2; v++) begin
        ins.op = bobx_pkg::bobx_op_t'(op);
        ins.bitno = 3'h4;
        mem_byte = v ? 8'h10 : 8'hef;
        tk = ((op == 9) || (op == 11)) == v[0];
        p0 = pushes;
        run(4'h0);
        chk(dn_pl, tk);
        if (tk) chk(dn_pa, ins.target);
        chk(pushes - p0, (op > 10) && tk);
        if ((op > 10) && tk) chk(push_w, 32'h0000_1004);
      end
    end
    $display("bit-test transfers finished");
  endtask

  task automatic t_cond();
    bobx_pkg::bobx_flags_t fs [4];
    fs = '{4'h0, 4'h5, 4'ha, 4'h9};
    ins.op = bobx_pkg::COND_BRANCH;
    for (int s = 0; s < 4; s++) begin
      for (int c = 0; c < 16; c++) begin
        ins.cc = c[3:0];
        run(fs[s]);
        chk(dn_pl, cond_ok(c[3:0], fs[s]));
      end
    end
    $display("conditional branch finished");
  endtask

  task automatic t_flow();
    int p0;
    int rn;
    p0 = pushes;
    ins.op = bobx_pkg::ABSOLUTE_JUMP;
    run(4'h0);
    chk(dn_pa, ins.target);
    chk(pushes - p0, 0);
    for (int op = 16; op < 18; op++) begin
      ins.op = bobx_pkg::bobx_op_t'(op);
      ins.words = op[0] ? 3'h1 : 3'h3;
      run(4'h0);
      chk(dn_pl, 1'h1);
      chk(dn_pa, ins.target);
      chk(push_w, 32'h0000_1000 + 2 * ins.words);
    end
    pi = 0;
    pops = '{32'h0000_3000, 32'h1111_2222, 32'h3333_4444, 32'h0000_3456};
    ins.op = bobx_pkg::SUB_RETURN;
    run(4'h0);
    chk(dn_pa, 32'h0000_3000);
    ins.op = bobx_pkg::SUB_RETURN_POP;
    ins.pop_cnt = 4'h2;
    ins.ridx = 4'h5;
    rn = rw_n;
    run(4'h0);
    chk(rw_n - rn, 2);
    chk(rw_i[rn[2:0]], 4'h5);
    chk(rw_d[rn[2:0]], 32'h1111_2222);
    chk(rw_i[3'(rn + 1)], 4'h6);
    chk(rw_d[3'(rn + 1)], 32'h3333_4444);
    chk(rw_b, 4'hf);
    chk(dn_pa, 32'h0000_3456);
    $display("jump call return finished");
  endtask

  task automatic t_delay();
    ins.op = bobx_pkg::DELAYED_BRANCH;
    ins.target = 32'h0000_5000;
    run(4'h0);
    chk(dn_pl, 1'h0);
    // one-word slot instruction, no branch
    ins.op = bobx_pkg::LOAD_BIT_TO_CARRY;
    ins.words = 3'h1;
    ins.mem_opnd = 1'h0;
    run(4'h0);
    chk(dn_cwe, 1'h1);
    chk(dn_pl, 1'h1);
    chk(dn_pa, 32'h0000_5000);
    $display("delayed branch finished");
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ==========================================================
  // main sequence
  initial begin
    ins.pc = 32'h0000_1000;
    ins.target = 32'h0000_2000;
    ins.ea = 32'h0000_0040;
    ins.words = 3'h2;
    repeat (3) @(posedge mclk);
    sys_rst <= 1'h0;
    t_carry();
    t_store();
    t_field();
    t_btest();
    t_cond();
    t_flow();
    t_delay();
    wrap_up();
  end
endmodule // bobx_exec_test
